// >>> src_ctrl.sv
// Sleep and reset controller top level
//
// Operation
// - Enabled sleep instruction enters the chosen mode; wake resumes after it.
// - Pending higher-priority interrupts are serviced first; core does that.
// - Core stays halted four cycles after every wake-up.
// - State is kept in sleep; a reset in sleep restarts from vector.
// - Idle stops core and memory clocks; peripherals run; any interrupt wakes.
// - Power-down stops all clocks; only address-match and pin wakes.
// - Power-save also keeps the enabled real-time counter and its wake.
// - Standby keeps clock sources running; core, peripheral, counter stop.
// - Extended standby is power-save plus clock sources kept running.
// - Cleared power reduction bit gates that peripheral clock off.
// - Reset holds while any source is active; pins float, vector loads.
// - Memory content is kept through reset; memory is outside this block.
// - Reset vector is 0, or the boot section base when configured.
// - Power-on and rst_n assertion act asynchronously; other reset sources are synchronised to ref_clk.
// - Cause flags set per source; power-on clears all but the power-on flag, which it sets.
// - Release runs delay, oscillator start, calibration; any reset restarts.
// - Supervisor reset request lasts one to two 2 MHz cycles.
// - Software reset bit resets within two core cycles.
// - Debug-port reset comes only from the debug port.
// - Supply dip detector forced on at lowest level in erase or debug when its fuse is off.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "src_params.svh"
module src_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ext_rst_n,
  input wire logic sup_req,
  input wire logic dip_req,
  input wire logic dbg_req,
  input wire logic dbg_en,
  input wire logic chip_erase,
  input wire logic dip_fuse_en,
  input wire logic boot_vec_sel,
  input wire logic [15:0] boot_base,
  input wire logic sleep_instr,
  input wire logic irq_any,
  input wire logic irq_twi_match,
  input wire logic irq_pin,
  input wire logic irq_rtc,
  input wire logic rtc_en,
  input wire logic [`SRC_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic sys_rst_n,
  output logic io_oe_n,
  output logic [15:0] reset_vector,
  output logic core_run,
  output logic core_clk_en,
  output logic nvm_clk_en,
  output logic per_clk_en,
  output logic rtc_clk_en,
  output logic src_clk_en,
  output logic [`SRC_NPER-1:0] per_gate_en,
  output logic dip_force_on,
  output logic dip_lowest,
  output logic osc_start,
  output logic osc_cal
);
  import src_pkg::*;

  logic ext_s, sup_s, dip_s, dbg_s, irq_any_s, irq_twi_s, irq_pin_s, irq_rtc_s;
  logic [7:0] sync_in, sync_out;
  assign sync_in = {irq_rtc, irq_pin, irq_twi_match, irq_any,
                    dbg_req, dip_req, sup_req, ~ext_rst_n};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      src_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d(sync_in[gi]),
        .q(sync_out[gi])
      );
    end
  endgenerate
  assign {irq_rtc_s, irq_pin_s, irq_twi_s, irq_any_s,
          dbg_s, dip_s, sup_s, ext_s} = sync_out;

  // no memory here; reset leaves it alone
  logic sleep_en_reg;
  src_mode_t mode_reg;
  logic [`SRC_NPER-1:0] pwrred_reg;
  logic swrst_reg;
  logic [5:0] cause_reg, cause_next;
  src_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] halt_reg;

  // supervisor pulse outlives sync; power-on async
  logic any_req;
  assign any_req = ext_s | sup_s | dip_s | dbg_s | swrst_reg;
  logic arst_n;
  assign arst_n = rst_n & por_n;

  logic hold_n_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      hold_n_reg <= 1'b0;
    else
      hold_n_reg <= ~any_req;
  end

  logic wr_sleep, wr_pwr, wr_rst;
  assign wr_sleep = wr_en && addr == `SRC_OFF_SLEEP;
  assign wr_pwr = wr_en && addr == `SRC_OFF_PWRRED;
  assign wr_rst = wr_en && addr == `SRC_OFF_RSTCTRL;

  // gating register reset by power-on and by every other reset source
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_en_reg <= 1'b0;
      mode_reg <= SRC_MODE_IDLE;
      pwrred_reg <= '1;
    end else if (!hold_n_reg) begin
      sleep_en_reg <= 1'b0;
      mode_reg <= SRC_MODE_IDLE;
      pwrred_reg <= '1;
    end else begin
      if (wr_sleep) begin
        sleep_en_reg <= wdata[`SRC_SLEEP_EN_BIT];
        mode_reg <= src_mode_t'(wdata[`SRC_SLEEP_MODE_LSB +: 3]);
      end
      if (wr_pwr)
        pwrred_reg <= wdata;
    end
  end

  // software reset bit, held until reset takes it away
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      swrst_reg <= 1'b0;
    else if (!hold_n_reg)
      swrst_reg <= 1'b0;
    else if (wr_rst && wdata[`SRC_SWRST_BIT])
      swrst_reg <= 1'b1;
  end

  // cause flags, cleared only by power-on
  always_comb begin
    cause_next = cause_reg;
    if (ext_s)
      cause_next[`SRC_CAUSE_EXT] = 1'b1;
    if (sup_s)
      cause_next[`SRC_CAUSE_SUP] = 1'b1;
    if (dip_s)
      cause_next[`SRC_CAUSE_DIP] = 1'b1;
    // debug source from its port only
    if (dbg_s)
      cause_next[`SRC_CAUSE_DBG] = 1'b1;
    if (swrst_reg)
      cause_next[`SRC_CAUSE_SW] = 1'b1;
  end
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n)
      cause_reg <= 6'h01;
    else
      cause_reg <= cause_next;
  end

  logic wake;
  logic rtc_wake;
  assign rtc_wake = rtc_en && irq_rtc_s;
  always_comb begin
    case (mode_reg)
      SRC_MODE_IDLE: wake = irq_any_s;
      SRC_MODE_PDOWN: wake = irq_twi_s | irq_pin_s;
      SRC_MODE_PSAVE: wake = irq_twi_s | irq_pin_s | rtc_wake;
      SRC_MODE_STBY: wake = irq_twi_s | irq_pin_s;
      SRC_MODE_ESTBY: wake = irq_twi_s | irq_pin_s | rtc_wake;
      default: wake = irq_any_s;
    endcase
  end

  // release sequence and sleep state machine
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      SRC_ST_RESET: begin
        state_next = SRC_ST_DELAY;
        cnt_next = 16'(`SRC_DLY_CYC - 1);
      end
      SRC_ST_DELAY: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0000) begin
          state_next = SRC_ST_OSC;
          cnt_next = `SRC_OSC_CYC - 16'h0001;
        end
      end
      SRC_ST_OSC: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0000) begin
          state_next = SRC_ST_CAL;
          cnt_next = `SRC_CAL_CYC - 16'h0001;
        end
      end
      SRC_ST_CAL: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0000)
          state_next = SRC_ST_RUN;
      end
      SRC_ST_RUN: begin
        if (sleep_instr && sleep_en_reg)
          state_next = SRC_ST_SLEEP;
      end
      SRC_ST_SLEEP: begin
        if (wake)
          state_next = SRC_ST_HALT;
      end
      SRC_ST_HALT: begin
        if (halt_reg == 3'h1)
          state_next = SRC_ST_RUN;
      end
      default: state_next = SRC_ST_RESET;
    endcase
  end

  // reset in any state, sleep included, restarts the sequence
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SRC_ST_RESET;
      cnt_reg <= 16'h0000;
    end else if (!hold_n_reg) begin
      state_reg <= SRC_ST_RESET;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      halt_reg <= 3'h0;
    else if (state_reg == SRC_ST_SLEEP && wake)
      halt_reg <= `SRC_WAKE_HALT_CYC;
    else if (halt_reg != 3'h0)
      halt_reg <= halt_reg - 3'h1;
  end

  // Clock enables per state and mode
  logic in_sleep, running, keep_src, keep_rtc, idle;
  assign in_sleep = state_reg == SRC_ST_SLEEP;
  assign running = state_reg == SRC_ST_RUN;
  assign idle = in_sleep && mode_reg == SRC_MODE_IDLE;
  assign keep_src = in_sleep &&
    (mode_reg == SRC_MODE_STBY || mode_reg == SRC_MODE_ESTBY);
  assign keep_rtc = rtc_en && in_sleep &&
    (mode_reg == SRC_MODE_PSAVE || mode_reg == SRC_MODE_ESTBY);
  logic active_clk;
  assign active_clk = running || state_reg == SRC_ST_HALT;

  logic [15:0] vec_next;
  assign vec_next = boot_vec_sel ? boot_base : `SRC_BOOT_VEC;

  logic dip_force;
  assign dip_force = ~dip_fuse_en & (chip_erase | dbg_en);

  // Register reads
  logic [7:0] rd_mux;
  assign rd_mux =
    addr == `SRC_OFF_SLEEP ? {4'h0, mode_reg, sleep_en_reg} :
    addr == `SRC_OFF_PWRRED ? pwrred_reg :
    addr == `SRC_OFF_RSTCTRL ? {7'h00, swrst_reg} :
    addr == `SRC_OFF_RSTCAUSE ? {2'h0, cause_reg} :
    addr == `SRC_OFF_STATE ? {5'h00, state_reg} :
    8'h00;

  // outputs held in reset; pins float at once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_rst_n <= 1'b0;
      io_oe_n <= 1'b1;
      reset_vector <= `SRC_BOOT_VEC;
      core_run <= 1'b0;
      core_clk_en <= 1'b0;
      nvm_clk_en <= 1'b0;
      per_clk_en <= 1'b0;
      rtc_clk_en <= 1'b0;
      src_clk_en <= 1'b0;
      per_gate_en <= '0;
      dip_force_on <= 1'b0;
      dip_lowest <= 1'b0;
      osc_start <= 1'b0;
      osc_cal <= 1'b0;
      rdata <= 8'h00;
    end else begin
      sys_rst_n <= hold_n_reg && state_reg != SRC_ST_RESET;
      io_oe_n <= ~(hold_n_reg && active_clk);
      reset_vector <= vec_next;
      core_run <= hold_n_reg && running && !(sleep_instr && sleep_en_reg);
      core_clk_en <= hold_n_reg && active_clk;
      nvm_clk_en <= hold_n_reg && active_clk;
      per_clk_en <= hold_n_reg && (active_clk || idle);
      rtc_clk_en <= hold_n_reg && rtc_en && (active_clk || idle || keep_rtc);
      src_clk_en <= hold_n_reg && (active_clk || idle || keep_src);
      // power reduction gating in active and idle
      per_gate_en <= (hold_n_reg && (active_clk || idle)) ? pwrred_reg : '0;
      dip_force_on <= dip_force;
      dip_lowest <= dip_force;
      osc_start <= state_reg == SRC_ST_OSC;
      osc_cal <= state_reg == SRC_ST_CAL;
      rdata <= rd_en ? rd_mux : 8'h00;
    end
  end

  // core does not run during four cycles after wake
  sequence wake_seq;
    state_reg == SRC_ST_SLEEP && wake;
  endsequence
  wake_halt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wake_seq |=> (state_reg == SRC_ST_HALT)[*4] ##1 state_reg == SRC_ST_RUN)
    else $error("halt after wake not four cycles");
  sleep_entry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    running && sleep_instr && !sleep_en_reg && hold_n_reg |=> !in_sleep)
    else $error("sleep entered without enable");
  swrst_time_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_rst && wdata[0] && hold_n_reg |-> ##[1:2] !hold_n_reg)
    else $error("software reset too slow");
  pd_clocks_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    in_sleep && mode_reg == SRC_MODE_PDOWN && hold_n_reg |=>
      !core_clk_en && !per_clk_en && !rtc_clk_en && !src_clk_en)
    else $error("clock running in power-down");
  idle_clocks_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    idle && hold_n_reg |=> per_clk_en && !core_clk_en && !nvm_clk_en)
    else $error("idle clocks wrong");
  pd_wake_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    in_sleep && mode_reg == SRC_MODE_PDOWN && !irq_twi_s && !irq_pin_s
      && hold_n_reg |=> in_sleep)
    else $error("illegal wake from power-down");
  stby_clocks_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    in_sleep && mode_reg == SRC_MODE_STBY && hold_n_reg |=>
      src_clk_en && !rtc_clk_en && !per_clk_en)
    else $error("standby clocks wrong");
  seq_restart_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !hold_n_reg |=> state_reg == SRC_ST_RESET ##1 1'b1)
    else $error("reset did not restart sequence");
  seq_order_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == SRC_ST_DELAY && state_next == SRC_ST_OSC && hold_n_reg
      |=> state_reg == SRC_ST_OSC)
    else $error("release stages out of order");
  hold_rst_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    any_req |=> ##1 !sys_rst_n && io_oe_n)
    else $error("reset not held while requested");
  cause_sticky_a: assert property (@(posedge ref_clk) disable iff (!por_n)
    ext_s |=> cause_reg[`SRC_CAUSE_EXT])
    else $error("cause flag not set");
  gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    running && hold_n_reg |=> per_gate_en == $past(pwrred_reg))
    else $error("peripheral gating wrong");
endmodule : src_ctrl
`default_nettype wire

// >>> src_params.svh
// Constants for the sleep and reset controller
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH
`define SRC_ADDR_W 4
`define SRC_OFF_SLEEP 4'h0
`define SRC_OFF_PWRRED 4'h1
`define SRC_OFF_RSTCTRL 4'h2
`define SRC_OFF_RSTCAUSE 4'h3
`define SRC_OFF_STATE 4'h4
`define SRC_OFF_VECTOR 4'h5
`define SRC_SLEEP_EN_BIT 0
`define SRC_SLEEP_MODE_LSB 1
`define SRC_SWRST_BIT 0
`define SRC_WAKE_HALT_CYC 3'h4
`define SRC_CLK_HZ 10000000
`define SRC_DLY_US 64
`define SRC_DLY_CYC ((`SRC_DLY_US * (`SRC_CLK_HZ / 1000000)))
`define SRC_OSC_CYC 16'h0040
`define SRC_CAL_CYC 16'h0020
`define SRC_SUP_MIN_NS 500
`define SRC_CLK_NS 100
`define SRC_SUP_MIN_CYC ((`SRC_SUP_MIN_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`define SRC_SUP_MAX_CYC ((2 * `SRC_SUP_MIN_NS) / `SRC_CLK_NS)
`define SRC_NPER 8
`define SRC_CAUSE_POR 0
`define SRC_CAUSE_EXT 1
`define SRC_CAUSE_SUP 2
`define SRC_CAUSE_DIP 3
`define SRC_CAUSE_DBG 4
`define SRC_CAUSE_SW 5
`define SRC_BOOT_VEC 16'h0000
`endif

// >>> src_pkg.sv
// Types for the sleep and reset controller
package src_pkg;
  typedef enum logic [2:0] {
    SRC_MODE_IDLE = 3'h0,
    SRC_MODE_PDOWN = 3'h1,
    SRC_MODE_PSAVE = 3'h2,
    SRC_MODE_STBY = 3'h3,
    SRC_MODE_ESTBY = 3'h4
  } src_mode_t;
  typedef enum logic [2:0] {
    SRC_ST_RESET = 3'h0,
    SRC_ST_DELAY = 3'h1,
    SRC_ST_OSC = 3'h2,
    SRC_ST_CAL = 3'h3,
    SRC_ST_RUN = 3'h4,
    SRC_ST_SLEEP = 3'h5,
    SRC_ST_HALT = 3'h6
  } src_state_t;
endpackage : src_pkg

// >>> src_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module src_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule : src_sync
`default_nettype wire

// >>> src_core_model.sv
// Behavioural model of the core and interrupt sources around the block
`timescale 1ns/10ps
`default_nettype none
module src_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic core_run,
  input wire logic go_sleep,
  input wire logic [3:0] wake_sel,
  output var logic sleep_instr,
  output logic irq_any,
  output logic irq_twi_match,
  output logic irq_pin,
  output logic irq_rtc
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= go_sleep & core_run & !sleep_instr;
    end
  end
  assign {irq_any, irq_twi_match, irq_pin, irq_rtc} = wake_sel & {4{!core_run}};
endmodule : src_core_model
`default_nettype wire

// >>> sleep_and_reset_controller_tb_top.sv
// Testbench for the sleep and reset controller
`timescale 1ns/10ps
`default_nettype none
`include "src_params.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  miscompares++; end end
module sleep_and_reset_controller_tb_top;
  import src_pkg::*;
  logic ref_clk = 0, rst_n = 0, por_n = 0, ext_rst_n = 1, rtc_en = 1;
  logic sup_req = 0, dip_req = 0, dbg_req = 0, dbg_en = 0, chip_erase = 0;
  logic dip_fuse_en = 1, boot_vec_sel = 0, wr_en = 0, rd_en = 0, go_sleep = 0;
  logic [15:0] boot_base = 16'h1C00;
  logic [3:0] addr = 4'h0, wake_sel = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, per_gate_en, d;
  logic [15:0] reset_vector;
  logic sys_rst_n, io_oe_n, core_run, core_clk_en, nvm_clk_en, per_clk_en;
  logic rtc_clk_en, src_clk_en, dip_force_on, dip_lowest, osc_start, osc_cal;
  logic sleep_instr, irq_any, irq_twi_match, irq_pin, irq_rtc;
  logic [2:0] ex_clk [5] = '{3'b100, 3'b000, 3'b010, 3'b001, 3'b011};
  logic [2:0] care [5] = '{3'b100, 3'b111, 3'b111, 3'b111, 3'b111};
  logic [3:0] good [5] = '{4'b1000, 4'b0010, 4'b0001, 4'b0100, 4'b0001};
  logic [3:0] bad [5] = '{4'b0000, 4'b0001, 4'b1000, 4'b0001, 4'b1000};
  int miscompares = 0, tests_run = 0, cyc = 0, n_osc = 0, n_cal = 0, n_low = 0;
  int i, m, k;
  wire any_req = !ext_rst_n | sup_req | dip_req | dbg_req | !por_n;
  src_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n),
    .ext_rst_n(ext_rst_n), .sup_req(sup_req), .dip_req(dip_req),
    .dbg_req(dbg_req), .dbg_en(dbg_en), .chip_erase(chip_erase),
    .dip_fuse_en(dip_fuse_en), .boot_vec_sel(boot_vec_sel),
    .boot_base(boot_base), .sleep_instr(sleep_instr), .irq_any(irq_any),
    .irq_twi_match(irq_twi_match), .irq_pin(irq_pin), .irq_rtc(irq_rtc),
    .rtc_en(rtc_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sys_rst_n(sys_rst_n), .io_oe_n(io_oe_n),
    .reset_vector(reset_vector), .core_run(core_run),
    .core_clk_en(core_clk_en), .nvm_clk_en(nvm_clk_en),
    .per_clk_en(per_clk_en), .rtc_clk_en(rtc_clk_en),
    .src_clk_en(src_clk_en), .per_gate_en(per_gate_en),
    .dip_force_on(dip_force_on), .dip_lowest(dip_lowest),
    .osc_start(osc_start), .osc_cal(osc_cal));
  src_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .core_run(core_run),
    .go_sleep(go_sleep), .wake_sel(wake_sel), .sleep_instr(sleep_instr),
    .irq_any(irq_any), .irq_twi_match(irq_twi_match), .irq_pin(irq_pin),
    .irq_rtc(irq_rtc));
  always #50 ref_clk = ~ref_clk;
  // Stage lengths measured from the last release of every request
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
    if (any_req) begin
      n_osc <= 0;
      n_cal <= 0;
      n_low <= 0;
    end else begin
      n_osc <= n_osc + int'(osc_start);
      n_cal <= n_cal + int'(osc_cal);
      n_low <= n_low + int'(!core_run);
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_run;
    for (int j = 0; j < 3000 && core_run !== 1'b1; j++) @(posedge ref_clk);
    #1;
    `CHK("run", 1'b1, core_run)
    `CHK("pins driven", 1'b0, io_oe_n)
  endtask : wait_run
  task automatic set_req(input int s, input logic v);
    case (s)
      `SRC_CAUSE_EXT: ext_rst_n <= !v;
      `SRC_CAUSE_SUP: sup_req <= v;
      `SRC_CAUSE_DIP: dip_req <= v;
      default: dbg_req <= v;
    endcase
  endtask : set_req
  // Nine cycles is within the one to two slow-oscillator cycle pulse
  task automatic req(input int s);
    @(posedge ref_clk);
    set_req(s, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK("held", 1'b0, sys_rst_n)
    `CHK("floating", 1'b1, io_oe_n)
    @(posedge ref_clk);
    set_req(s, 1'b0);
  endtask : req
  task automatic nap(input int md, input logic en);
    wr(`SRC_OFF_SLEEP, {4'h0, 3'(md), en});
    @(posedge ref_clk);
    go_sleep <= 1'b1;
    @(posedge ref_clk);
    go_sleep <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : nap
  initial begin
    repeat (2) @(posedge ref_clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    wait_run;
    `CHK("osc stage", `SRC_OSC_CYC, n_osc)
    `CHK("cal stage", `SRC_CAL_CYC, n_cal)
    `CHK("sequence long", 1'b1, n_low >= 736)
    `CHK("vector", 16'h0000, reset_vector)
    rd(`SRC_OFF_RSTCAUSE);
    `CHK("cause por", 8'h01, d)
    rd(`SRC_OFF_PWRRED);
    `CHK("pwrred init", 8'hFF, d)
    rd(4'hF);
    `CHK("unmapped", 8'h00, d)
    rd(`SRC_OFF_STATE);
    `CHK("state run", {5'h0, SRC_ST_RUN}, d)
    $display("test power-on done");
    nap(1, 1'b0);
    `CHK("no enable", 1'b1, core_run)
    wr(`SRC_OFF_PWRRED, 8'h5A);
    @(posedge ref_clk);
    #1 `CHK("gating", 8'h5A, per_gate_en)
    $display("test enable and gating done");
    for (m = 0; m < 5; m++) begin
      nap(m, 1'b1);
      `CHK("asleep", 1'b0, core_run)
      `CHK("core clk", 1'b0, core_clk_en)
      `CHK("nvm clk", 1'b0, nvm_clk_en)
      `CHK("clks", ex_clk[m] & care[m],
        {per_clk_en, rtc_clk_en, src_clk_en} & care[m])
      `CHK("idle gating", (m == 0) ? 8'h5A : 8'h00, per_gate_en)
      @(posedge ref_clk);
      wake_sel <= bad[m];
      repeat (10) @(posedge ref_clk);
      #1 `CHK("no wake", 1'b0, core_run)
      @(posedge ref_clk);
      wake_sel <= good[m];
      for (k = 0; k < 50 && core_run !== 1'b1; k++) @(posedge ref_clk);
      // Two sync edges, wake edge, four halt cycles, run edge, one to see it
      `CHK("halt cycles", 9, k)
      wake_sel <= 4'h0;
      rd(`SRC_OFF_STATE);
      `CHK("resumed", {5'h0, SRC_ST_RUN}, d)
    end
    $display("test sleep modes done");
    nap(1, 1'b1);
    req(`SRC_CAUSE_EXT);
    wait_run;
    rd(`SRC_OFF_SLEEP);
    `CHK("sleep cleared", 8'h00, d)
    rd(`SRC_OFF_PWRRED);
    `CHK("pwrred cleared", 8'hFF, d)
    for (i = `SRC_CAUSE_SUP; i <= `SRC_CAUSE_DBG; i++) begin
      req(i);
      wait_run;
    end
    req(`SRC_CAUSE_EXT);
    repeat (700) @(posedge ref_clk);
    req(`SRC_CAUSE_EXT);
    wait_run;
    `CHK("restart osc", `SRC_OSC_CYC, n_osc)
    `CHK("restart long", 1'b1, n_low >= 736)
    rd(`SRC_OFF_RSTCAUSE);
    `CHK("cause sources", 8'h1F, d)
    $display("test reset sources done");
    @(posedge ref_clk);
    boot_vec_sel <= 1'b1;
    wr(`SRC_OFF_RSTCTRL, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 `CHK("sw reset", 1'b0, sys_rst_n)
    wait_run;
    `CHK("boot vector", 16'h1C00, reset_vector)
    rd(`SRC_OFF_RSTCAUSE);
    `CHK("cause sw", 8'h3F, d)
    $display("test software reset done");
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {dip_fuse_en, dbg_en, chip_erase} <= 3'(i);
      repeat (3) @(posedge ref_clk);
      #1 `CHK("dip force", i[2] == 0 && i[1:0] != 0, dip_force_on)
      if (i[2] == 0 && i[1:0] != 0) begin
        `CHK("dip lowest", 1'b1, dip_lowest)
      end
    end
    $display("test supply dip done");
    @(posedge ref_clk);
    por_n <= 1'b0;
    #5 `CHK("async reset", 1'b0, sys_rst_n)
    @(posedge ref_clk);
    por_n <= 1'b1;
    wait_run;
    rd(`SRC_OFF_RSTCAUSE);
    `CHK("cause after por", 8'h01, d)
    $display("test power-on again done");
    conclude();
  end
endmodule : sleep_and_reset_controller_tb_top
`default_nettype wire
